// ### hw/bsw_defs.svh
// register offsets, field positions and reset values of the burst sram
`ifndef BSW_DEFS_SVH
`define BSW_DEFS_SVH
`define BSW_CTRL_OFF 12'h000
`define BSW_STAT_OFF 12'h004
`define BSW_WCNT_OFF 12'h008
`define BSW_CTRL_WEN 0
`define BSW_CTRL_LIN 1
`define BSW_CTRL_RST 2'h1
`define BSW_WCNT_RST 16'h0000
`endif

// ### hw/bsw_pkg.sv
// types shared by the burst sram modules
package bsw_pkg;
    typedef enum logic [1:0] {
        BSW_IDLE,
        BSW_ARMED,
        BSW_BURST
    } bsw_state_t;
endpackage

// ### hw/bsw_reg_if.sv
// control and status bundle between the register slave and the core
`timescale 1ns/1ps
interface bsw_reg_if;
    logic                  wr_allow;
    logic                  linear_order;
    logic                  wcnt_clr;
    bsw_pkg::bsw_state_t   st;
    logic [1:0]            burst_pos;
    logic [15:0]           wcount;
    modport regs (output wr_allow, output linear_order, output wcnt_clr,
                  input st, input burst_pos, input wcount);
    modport core (input wr_allow, input linear_order, input wcnt_clr,
                  output st, output burst_pos, output wcount);
endinterface

// ### hw/bsw_burst_ctr.sv
// burst counter producing the low-order word address of each transfer
`timescale 1ns/1ps
module bsw_burst_ctr #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         load,
    input  wire logic         step,
    input  wire logic         linear,
    input  wire logic [W-1:0] base_lo,
    output logic      [W-1:0] pos_q,
    output logic      [W-1:0] lo_now,
    output logic      [W-1:0] lo_step
);
    logic [W-1:0] pos_d;
    logic [W-1:0] pos_inc;

    // load restarts at the base, step moves one, otherwise hold
    always_comb begin
        pos_inc = pos_q + 1'b1;
        pos_d   = load ? '0 : (step ? pos_inc : pos_q);
        // interleaved order mirrors the processor's line fill sequence
        lo_now  = linear ? W'(base_lo + pos_q) : (base_lo ^ pos_q);
        lo_step = linear ? W'(base_lo + pos_inc) : (base_lo ^ pos_inc);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pos_q <= '0;
        end else begin
            pos_q <= pos_d;
        end
    end
endmodule

// ### hw/bsw_apb_regs.sv
// apb slave holding control, status and write count registers
`timescale 1ns/1ps
`include "bsw_defs.svh"
module bsw_apb_regs (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    bsw_reg_if.regs          rif
);
    logic [1:0]  ctrl_q, ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;
    logic        hit;
    logic        wr_acc;

    // decode in setup so data and error stand ready for the access edge
    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0;
        case (paddr)
            `BSW_CTRL_OFF: rdata_d = {30'h0, ctrl_q};
            `BSW_STAT_OFF: rdata_d = {28'h0, rif.burst_pos, rif.st};
            `BSW_WCNT_OFF: rdata_d = {16'h0, rif.wcount};
            default:       hit = 1'b0;
        endcase
        if (!(psel && !penable)) begin
            rdata_d = rdata_q;
        end
        err_d  = (psel && !penable) ? !hit : err_q;
        wr_acc = psel && penable && pwrite;
        ctrl_d = ctrl_q;
        if (wr_acc && paddr == `BSW_CTRL_OFF) begin
            ctrl_d = pwdata[1:0];
        end
        rif.wcnt_clr = wr_acc && paddr == `BSW_WCNT_OFF;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q  <= `BSW_CTRL_RST;
            rdata_q <= 32'h0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // zero wait state slave
    assign pready           = 1'b1;
    assign prdata           = rdata_q;
    assign pslverr          = err_q && psel && penable;
    assign rif.wr_allow     = ctrl_q[`BSW_CTRL_WEN];
    assign rif.linear_order = ctrl_q[`BSW_CTRL_LIN];
endmodule

// ### hw/bsw_top.sv
// synchronous burst sram slice with self-timed burst writes
// Notes on behaviour
// - a burst write may start from either the processor or the controller address strobe.
// - a controller strobe start with the processor strobe high writes data in that same cycle.
// - a processor strobe start blocks the write and captures only the address and select.
// - after a processor start the write begins on the next cycle with both strobes negated.
// - data and byte strobes are sampled at the clock edge and the write is timed inside.
// - four such 18-bit slices form one 64-bit bank wired straight to address and data.
// - address, write and enable inputs are captured only on the rising clock edge.
// - strobe, step, select and byte-write inputs are asserted when low.
// - the start address is the base from which the burst counter makes later addresses.
`timescale 1ns/1ps
`include "bsw_defs.svh"
module bsw_top #(
    parameter int ADDR_W  = 16,
    parameter int DATA_W  = 18,
    parameter int BURST_W = 2
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              chip_sel_n,
    input  wire logic              processor_side_addr_strobe_n,
    input  wire logic              controller_side_addr_strobe_n,
    input  wire logic              burst_step_n,
    input  wire logic              low_byte_write_strobe_n,
    input  wire logic              upper_byte_write_strobe_n,
    input  wire logic              out_en_n,
    input  wire logic [DATA_W-1:0] dq_i,
    output logic      [DATA_W-1:0] dq_o,
    output logic                   dq_oe
);
    localparam int HALF  = DATA_W / 2;
    localparam int DEPTH = 1 << ADDR_W;

    // refuse shapes the byte halves and burst counter cannot serve
    if (DATA_W % 2 != 0 || BURST_W < 1 || BURST_W >= ADDR_W || ADDR_W > 20) begin : g_chk
        $error("bsw_top: unsupported parameter set");
    end

    bsw_reg_if rif ();

    bsw_pkg::bsw_state_t state_q, state_d;
    logic [ADDR_W-1:0]   base_q, base_d;
    logic [15:0]         wcount_q, wcount_d;
    logic [DATA_W-1:0]   mem_q [DEPTH];
    logic [DATA_W-1:0]   dq_o_q, dq_o_d;
    logic                dq_oe_q, dq_oe_d;
    logic                processor_side_addr_strobe, controller_side_addr_strobe, sel, step, lw, uw, any_be;
    logic                start_p, start_c;
    logic                load, burst_step, wr_req, wr_en;
    logic [ADDR_W-1:0]   wr_addr, rd_addr;
    logic [DATA_W-1:0]   wr_word, old_word;
    logic [1:0]          be;
    logic [BURST_W-1:0]  pos_q, lo_now, lo_step;

    always_comb begin
        processor_side_addr_strobe   = !processor_side_addr_strobe_n;
        controller_side_addr_strobe   = !controller_side_addr_strobe_n;
        sel    = !chip_sel_n;
        step   = !burst_step_n;
        lw     = !low_byte_write_strobe_n;
        uw     = !upper_byte_write_strobe_n;
        be     = {uw, lw};
        any_be = lw || uw;
    end

    // two start sequences
    // both strobes low is taken as a processor start, the safer one
    always_comb begin
        start_p = processor_side_addr_strobe && sel;
        start_c = controller_side_addr_strobe && !processor_side_addr_strobe && sel;
    end

    // sequencer: next state, base capture and the write request
    always_comb begin
        state_d = state_q;
        base_d  = base_q;
        load    = 1'b0;
        burst_step     = 1'b0;
        wr_req  = 1'b0;
        wr_addr = {base_q[ADDR_W-1:BURST_W], lo_now};
        if (start_p) begin
            state_d = bsw_pkg::BSW_ARMED;
            base_d  = addr;
            load    = 1'b1;
        end else if (start_c) begin
            // write in the start cycle itself
            state_d = bsw_pkg::BSW_BURST;
            base_d  = addr;
            load    = 1'b1;
            wr_req  = any_be;
            wr_addr = addr;
        end else if (processor_side_addr_strobe || controller_side_addr_strobe) begin
            // a strobe with select negated ends any burst
            state_d = bsw_pkg::BSW_IDLE;
        end else begin
            case (state_q)
                bsw_pkg::BSW_IDLE: begin
                    state_d = bsw_pkg::BSW_IDLE;
                end
                bsw_pkg::BSW_ARMED: begin
                    // first write after a processor start
                    state_d = bsw_pkg::BSW_BURST;
                    wr_req  = any_be;
                end
                bsw_pkg::BSW_BURST: begin
                    // relies on step for later transfers
                    if (step) begin
                        burst_step     = 1'b1;
                        wr_req  = any_be;
                        wr_addr = {base_q[ADDR_W-1:BURST_W], lo_step};
                    end
                end
                default: begin
                    state_d = bsw_pkg::BSW_IDLE;
                end
            endcase
        end
        wr_en = wr_req && rif.wr_allow;
    end

    // low bits come from the counter, seeded by the base
    bsw_burst_ctr #(
        .W (BURST_W)
    ) u_ctr (
        .clk     (clk),
        .rst     (rst),
        .load    (load),
        .step    (burst_step),
        .linear  (rif.linear_order),
        .base_lo (load ? addr[BURST_W-1:0] : base_q[BURST_W-1:0]),
        .pos_q   (pos_q),
        .lo_now  (lo_now),
        .lo_step (lo_step)
    );

    // merge per half, one strobe per nine bits
    assign old_word = mem_q[wr_addr];
    for (genvar h = 0; h < 2; h++) begin : g_half
        assign wr_word[h*HALF +: HALF] = be[h] ? dq_i[h*HALF +: HALF]
                                                : old_word[h*HALF +: HALF];
    end

    // read side: word at the current burst address, oe when not writing
    always_comb begin
        rd_addr = {base_q[ADDR_W-1:BURST_W], lo_now};
        dq_o_d  = mem_q[rd_addr];
        dq_oe_d = !out_en_n && state_q != bsw_pkg::BSW_IDLE && !any_be;
    end

    // write count: a write in the clear cycle still counts
    always_comb begin
        if (rif.wcnt_clr) begin
            wcount_d = {15'h0, wr_en};
        end else begin
            wcount_d = wcount_q + {15'h0, wr_en};
        end
    end

    // all inputs taken on the rising edge only
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q  <= bsw_pkg::BSW_IDLE;
            base_q   <= '0;
            wcount_q <= `BSW_WCNT_RST;
            dq_o_q   <= '0;
            dq_oe_q  <= 1'b0;
        end else begin
            state_q  <= state_d;
            base_q   <= base_d;
            wcount_q <= wcount_d;
            dq_o_q   <= dq_o_d;
            dq_oe_q  <= dq_oe_d;
        end
    end

    // self-timed write at the sampling edge, no pulse outside
    // one quarter of the 64-bit bank data path
    // storage has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_word;
        end
    end

    assign dq_o          = dq_o_q;
    assign dq_oe         = dq_oe_q;
    assign rif.st        = state_q;
    assign rif.burst_pos = 2'(pos_q);
    assign rif.wcount    = wcount_q;

    bsw_apb_regs u_regs (
        .clk     (clk),
        .rst     (rst),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .rif     (rif)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_controller_side_addr_strobe_write_now: assert property (
        (start_c && lw && uw && rif.wr_allow) |=> mem_q[$past(addr)] == $past(dq_i))
        else $error("controller start did not write in its own cycle");

    a_processor_side_addr_strobe_capture_only: assert property (
        start_p |-> !wr_en ##1 (state_q == bsw_pkg::BSW_ARMED && base_q == $past(addr)))
        else $error("processor start wrote or lost its address");

    a_armed_first_write: assert property (
        (state_q == bsw_pkg::BSW_ARMED && !processor_side_addr_strobe && !controller_side_addr_strobe && any_be && rif.wr_allow)
        |-> (wr_en && wr_addr == base_q))
        else $error("armed cycle did not write at the base address");

    a_step_moves_one: assert property (
        (state_q == bsw_pkg::BSW_BURST && !processor_side_addr_strobe && !controller_side_addr_strobe && step)
        |=> pos_q == BURST_W'($past(pos_q) + 1'b1))
        else $error("burst counter did not advance by one");

    a_pos_holds: assert property (
        (!step && !processor_side_addr_strobe && !controller_side_addr_strobe) |=> $stable(pos_q))
        else $error("burst counter moved without burst step");

    a_half_gate: assert property (
        (wr_en && lw && !uw)
        |=> mem_q[$past(wr_addr)][DATA_W-1:HALF] == $past(old_word[DATA_W-1:HALF]))
        else $error("upper half changed with its strobe negated");

    a_base_kept: assert property (
        (state_q != bsw_pkg::BSW_IDLE && wr_en && !processor_side_addr_strobe && !controller_side_addr_strobe)
        |-> wr_addr[ADDR_W-1:BURST_W] == base_q[ADDR_W-1:BURST_W])
        else $error("burst left the base line");

    a_desel_no_write: assert property (
        ((processor_side_addr_strobe || controller_side_addr_strobe) && chip_sel_n) |-> !wr_en ##1 state_q == bsw_pkg::BSW_IDLE)
        else $error("deselected start wrote or kept the burst");

    a_word_stored: assert property (
        wr_en |=> mem_q[$past(wr_addr)] == $past(wr_word))
        else $error("sampled word not stored at the edge");

    a_read_drive: assert property (
        (!out_en_n && state_q != bsw_pkg::BSW_IDLE && !any_be) |=> dq_oe)
        else $error("read data not driven");

    c_controller_side_addr_strobe_burst: cover property (start_c && wr_en ##1 burst_step [*3]);
    c_processor_side_addr_strobe_burst: cover property (start_p ##1 (state_q == bsw_pkg::BSW_ARMED && wr_en));
    c_wcnt_clear: cover property (rif.wcnt_clr && wr_en);
    c_apb_error:  cover property (pslverr);
endmodule

// ### verification/bsw_ctl_model.sv
// cache controller model that drives the pins of the burst sram slice
`timescale 1ns/1ps
module bsw_ctl_model (
    input  wire logic        clk,
    output logic [15:0]      addr,
    output logic             chip_sel_n,
    output logic             processor_side_addr_strobe_n,
    output logic             controller_side_addr_strobe_n,
    output logic             burst_step_n,
    output logic             low_byte_write_strobe_n,
    output logic             upper_byte_write_strobe_n,
    output logic             out_en_n,
    output logic [17:0]      dq_i,
    input  wire logic [17:0] dq_o,
    input  wire logic        dq_oe
);
    // every control negated at time zero so nothing starts early
    initial begin
        {processor_side_addr_strobe_n, controller_side_addr_strobe_n} = 2'h3;
        {burst_step_n, upper_byte_write_strobe_n, low_byte_write_strobe_n} = 3'h7;
        chip_sel_n = 1'b1;
        out_en_n = 1'b1;
        addr = 16'h0000;
        dq_i = 18'h00000;
    end

    // tag store depth for sectors of one, two or four lines
    localparam int TAG_DEPTH_1L = 16384;
    localparam int TAG_DEPTH_2L = 8192;
    localparam int TAG_DEPTH_4L = 4096;
    // tag width that spans the whole main memory
    localparam int TAG_W        = 8;

    // low-true controls, changed just after a rising edge
    task automatic drive(input logic [4:0] c, input logic oe_n,
                         input logic [15:0] a, input logic [17:0] d);
        @(posedge clk);
        {processor_side_addr_strobe_n, controller_side_addr_strobe_n, burst_step_n,
         upper_byte_write_strobe_n, low_byte_write_strobe_n} <= c;
        chip_sel_n <= c[4] & c[3];
        out_en_n   <= oe_n;
        addr       <= a;
        dq_i       <= d;
    endtask

    // released lines flip every cycle so a stale value never looks valid
    task automatic idle();
        drive(5'h1f, 1'b1, ~addr, ~dq_i);
    endtask

    // select with strobe, step each later transfer
    task automatic burst(input logic proc, input logic [15:0] a,
                         input logic [3:0][17:0] w, input logic [1:0] be_n);
        if (proc) begin
            // byte strobes in the start cycle must not write
            // processor start spends one lead-off cycle
            drive({3'b011, be_n}, 1'b1, a, ~w[0]);
            drive({3'b110, be_n}, 1'b1, ~a, w[0]);
        end else begin
            drive({3'b101, be_n}, 1'b1, a, w[0]);
        end
        for (int i = 1; i < 4; i++) begin
            drive({3'b110, be_n}, 1'b1, ~a, w[i]);
        end
        idle();
    endtask

    // read data launches at the edge after the start is registered
    task automatic read_word(input logic [15:0] a, output logic [17:0] q,
                             output logic oe);
        drive(5'h17, 1'b0, a, ~dq_i);
        // strobes negated, output enable held up to the data edge
        drive(5'h1f, 1'b0, a, ~dq_i);
        @(posedge clk);
        #1;
        q  = dq_o;
        oe = dq_oe;
        idle();
    endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench of the burst sram slice with apb registers
`timescale 1ns/1ps
`include "bsw_defs.svh"
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fail_count++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (act), (exp)); end end
module tb_top;
    localparam logic [3:0][17:0] W1 = {18'h1a5a5, 18'h25a5a, 18'h0f0f0, 18'h30f0f};
    localparam logic [3:0][17:0] W2 = {18'h12345, 18'h2abcd, 18'h01111, 18'h3eeee};
    localparam logic [3:0][17:0] W3 = {18'h0c3c3, 18'h33c3c, 18'h15555, 18'h2aaaa};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] addr;
    logic        sel_n, ps_n, cs_n, step_n, lw_n, uw_n, oe_n, dq_oe;
    logic [17:0] dq_i, dq_o;
    int          fail_count = 0;
    int          samples_checked = 0;

    // free-running 125 MHz clock
    always #4 clk = ~clk;

    bsw_top dut_u (.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .addr(addr), .chip_sel_n(sel_n),
        .processor_side_addr_strobe_n(ps_n), .controller_side_addr_strobe_n(cs_n),
        .burst_step_n(step_n), .low_byte_write_strobe_n(lw_n),
        .upper_byte_write_strobe_n(uw_n), .out_en_n(oe_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe));
    bsw_ctl_model partner_u (.clk(clk), .addr(addr), .chip_sel_n(sel_n),
        .processor_side_addr_strobe_n(ps_n), .controller_side_addr_strobe_n(cs_n),
        .burst_step_n(step_n), .low_byte_write_strobe_n(lw_n),
        .upper_byte_write_strobe_n(uw_n), .out_en_n(oe_n), .dq_i(dq_i), .dq_o(dq_o),
        .dq_oe(dq_oe));

    // apb transfer: request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q   = prdata;
        err = pslverr;
        if (n >= 50) fail_count++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        `CHK(q, exp)
    endtask

    // reads back four words in burst order, wrapping inside the line
    task automatic check_burst(input logic [15:0] b, input logic lin,
                               input logic [3:0][17:0] w);
        logic [15:0] a;
        logic [17:0] q;
        logic        oe;
        for (int i = 0; i < 4; i++) begin
            a = lin ? {b[15:2], b[1:0] + 2'(i)} : b ^ 16'(i);
            partner_u.read_word(a, q, oe);
            `CHK(oe, 1'b1)
            `CHK(q, w[i])
        end
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        rd(`BSW_CTRL_OFF, {30'h0, `BSW_CTRL_RST});
        rd(`BSW_WCNT_OFF, {16'h0, `BSW_WCNT_RST});
        rd(`BSW_STAT_OFF, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, q, e);
        `CHK({e, q}, 33'h100000000)
    endtask

    // controller start writes in its own cycle, interleaved order
    task automatic t_ctl();
        partner_u.burst(1'b0, 16'h0005, W1, 2'b00);
        rd(`BSW_STAT_OFF, 32'h0000000e);
        check_burst(16'h0005, 1'b0, W1);
        rd(`BSW_WCNT_OFF, 32'h4);
    endtask

    // processor start only captures address; write follows a cycle later
    task automatic t_proc();
        wr(`BSW_WCNT_OFF, 32'h0);
        partner_u.burst(1'b1, 16'h0102, W2, 2'b00);
        check_burst(16'h0102, 1'b0, W2);
        rd(`BSW_WCNT_OFF, 32'h4);
    endtask

    // each strobe touches only its own half of the word
    task automatic t_bytes();
        logic [3:0][17:0] e;
        for (int i = 0; i < 4; i++) e[i] = {W3[i][17:9], W2[i][8:0]};
        partner_u.burst(1'b0, 16'h0020, W1, 2'b00);
        partner_u.burst(1'b0, 16'h0020, W2, 2'b10);
        partner_u.burst(1'b0, 16'h0020, W3, 2'b01);
        check_burst(16'h0020, 1'b0, e);
    endtask

    // step held off in mid-burst: no write, counter holds
    task automatic t_stall();
        logic [17:0] q;
        logic        oe;
        wr(`BSW_WCNT_OFF, 32'h0);
        partner_u.drive(5'h14, 1'b1, 16'h0040, W1[0]);
        partner_u.drive(5'h1c, 1'b1, 16'hffbf, W2[0]);
        partner_u.drive(5'h1c, 1'b1, 16'hffbf, W2[1]);
        partner_u.drive(5'h18, 1'b1, 16'hffbf, W1[1]);
        partner_u.idle();
        rd(`BSW_STAT_OFF, 32'h00000006);
        rd(`BSW_WCNT_OFF, 32'h2);
        partner_u.read_word(16'h0041, q, oe);
        `CHK(q, W1[1])
    endtask

    // linear order, then writes refused while write allow is off
    task automatic t_linear();
        wr(`BSW_CTRL_OFF, 32'h3);
        partner_u.burst(1'b0, 16'h0062, W3, 2'b00);
        check_burst(16'h0062, 1'b1, W3);
        wr(`BSW_CTRL_OFF, 32'h2);
        wr(`BSW_WCNT_OFF, 32'h0);
        partner_u.burst(1'b1, 16'h0062, W1, 2'b00);
        check_burst(16'h0062, 1'b1, W3);
        rd(`BSW_WCNT_OFF, 32'h0);
        wr(`BSW_CTRL_OFF, 32'h1);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #100000;
        fail_count++;
        conclude();
    end

    // reset for 20 cycles, then the scenarios in turn
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_ctl();
        t_proc();
        t_bytes();
        t_stall();
        t_linear();
        conclude();
    end
endmodule
